// ---- design/spl_pkg.sv ----
// Function
// - Opcode 39h plus three address bytes clears the sector bit at release.
// - Clear only executes when the write enable latch was already set.
// - Successful clear marks the sector unprotected and clears the latch.
// - Release before three address bytes aborts, keeps the bit, clears latch.
// - Serial input after the three address bytes is ignored.
// - With registers locked, clear is ignored and the latch is cleared.
// - Opcode 3Ch plus address; output driven every clock after last bit.
// - Protection read repeats 00h when unprotected, FFh when protected.
// - Release ends the read, output floats; partial bytes are fine.
// - Read data holds only the sector bit, never the pin level.
// - Sector protection depends only on its bit, not on the pin.
// - Hardware lock is active when the pin is low and lock bit is 1.
// - Hardware lock freezes sector bits and lock bit; ignores writes.
// - With the pin low, a set lock bit clears only by reset.
// - Lock bit 0 may go to 1 at either pin level; sectors modifiable.
// - Pin high with lock 1 freezes sectors but lock may return to 0.
// - One bit per physical sector; any address in the sector selects it.
// - Summary field reports all, some or no sectors protected.
// - Reset sets every sector protection bit to 1.
// - Reset clears the lock bit to 0.
// - Incomplete or unknown opcode leaves a set latch unchanged.
package spl_pkg;

   // ****************************************************************
   // Opcodes.
   // ****************************************************************
   localparam logic [7:0] OP_WR_EN   = 8'h06;
   localparam logic [7:0] OP_WR_DIS  = 8'h04;
   localparam logic [7:0] OP_PROTECT = 8'h36;
   localparam logic [7:0] OP_CLEAR   = 8'h39;
   localparam logic [7:0] OP_READ    = 8'h3C;
   localparam logic [7:0] OP_WR_STAT = 8'h01;

   // ****************************************************************
   // Frame lengths in serial bits.
   // ****************************************************************
   localparam logic [5:0] BITS_OPCODE = 6'h08;
   localparam logic [5:0] BITS_DATA   = 6'h10;
   localparam logic [5:0] BITS_ADDR   = 6'h20;

   // ****************************************************************
   // Summary field codes and reset values.
   // ****************************************************************
   localparam logic [1:0] SUM_NONE = 2'h0;
   localparam logic [1:0] SUM_SOME = 2'h1;
   localparam logic [1:0] SUM_ALL  = 2'h3;
   localparam logic       PROT_RESET = 1'h1;
   localparam logic       LOCK_RESET = 1'h0;
   localparam logic       LATCH_RESET = 1'h0;

   // ****************************************************************
   // Clock rate.
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 40;

   // Opcodes that change protection state and so obey the lock.
   function automatic logic is_prot_write(input logic [7:0] op);
      is_prot_write = (op == OP_PROTECT) || (op == OP_CLEAR);
   endfunction

endpackage

// ---- design/spl_sync.sv ----
`timescale 1ns/1ps
module spl_sync #(
   parameter int         WIDTH = 1,
   parameter logic [0:0] INIT  = 1'h1
) (
   // Clock and reset.
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // Asynchronous input and filtered level.
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] level
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // Three shift flops and a level flop per bit; the level follows once stages two and three agree.
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               stage1[i] <= INIT;
               stage2[i] <= INIT;
               stage3[i] <= INIT;
               level[i]  <= INIT;
            end else begin
               stage1[i] <= async_in[i];
               stage2[i] <= stage1[i];
               stage3[i] <= stage2[i];
               if (stage2[i] == stage3[i]) begin
                  level[i] <= stage3[i];
               end
            end
         end
      end
   endgenerate

endmodule

// ---- design/spl_sector_lock.sv ----
`timescale 1ns/1ps
module spl_sector_lock #(
   parameter int SECTORS      = 16,
   parameter int ADDR_W       = 24,
   parameter int SECTOR_SHIFT = 17
) (
   // System clock and reset.
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Serial link from the host.
   input  wire logic       spi_clk,
   input  wire logic       cs_n,
   input  wire logic       si,
   output      logic       so,
   output      logic       so_oe_n,
   // Write protect pin.
   input  wire logic       wp_n,
   // Status bits.
   output      logic       write_enable_latch,
   output      logic       protect_regs_lock_bit,
   output      logic [1:0] protect_summary_field,
   output      logic       wp_pin_status,
   output      logic [SECTORS-1:0] sector_protect_bit
);

   localparam int IDX_W = $clog2(SECTORS);

   // Refuse a sector map that does not fit inside the address.
   generate
      if (SECTORS < 2 || (1 << IDX_W) != SECTORS ||
          SECTOR_SHIFT + IDX_W > ADDR_W || ADDR_W > 24) begin : g_bad
         $error("spl_sector_lock: sector map does not fit the address");
      end
   endgenerate

   // ****************************************************************
   // Link domain: capture of opcode, address and data bit.
   // ****************************************************************
   logic              started;
   logic [5:0]        bit_cnt;
   logic [7:0]        opcode;
   logic [23:0]       addr_sh;
   logic              data_msb;
   logic              so_drive;
   logic              so_bit;
   wire  logic [5:0]  cnt_from = started ? bit_cnt : 6'h00;
   wire  logic        cnt_full = (cnt_from == spl_pkg::BITS_ADDR);
   wire  logic [IDX_W-1:0] rd_idx = addr_sh[SECTOR_SHIFT +: IDX_W];
   wire  logic        prot_rd = sector_protect_bit[rd_idx];

   // Frame start flag; cleared by the chip select release itself.
   always_ff @(posedge spi_clk or posedge cs_n) begin
      if (cs_n) begin
         started <= 1'h0;
      end else begin
         started <= 1'h1;
      end
   end

   // Bit counter saturates so that later input is ignored.
   always_ff @(posedge spi_clk) begin
      if (!cnt_full) begin
         bit_cnt <= cnt_from + 6'h01;
      end else begin
         bit_cnt <= cnt_from;
      end
   end

   // Opcode, then address bytes are shifted in; the first bit after the opcode is kept as data bit.
   always_ff @(posedge spi_clk) begin
      if (cnt_from < spl_pkg::BITS_OPCODE) begin
         opcode <= {(started ? opcode[6:0] : 7'h00), si};
      end
      if (cnt_from >= spl_pkg::BITS_OPCODE && !cnt_full) begin
         addr_sh <= {addr_sh[22:0], si};
      end
      if (cnt_from == spl_pkg::BITS_OPCODE) begin
         data_msb <= si;
      end
   end

   // Read data leaves on the falling edge once the address is complete.
   // The bit shows only the sector flag, so every byte is 00h or FFh.
   // Protection flags change only while chip select is high, so they
   // are static whenever this edge reads them.
   always_ff @(negedge spi_clk or posedge cs_n) begin
      if (cs_n) begin
         so_drive <= 1'h0;
         so_bit   <= 1'h0;
      end else begin
         if (opcode == spl_pkg::OP_READ && cnt_full) begin
            so_drive <= 1'h1;
         end
         so_bit <= prot_rd;
      end
   end

   // Serial output and its active low enable.
   assign so      = so_bit;
   assign so_oe_n = ~so_drive;

   // ****************************************************************
   // System domain: chip select release and pin sampling.
   // ****************************************************************
   logic [1:0] pins_lvl;
   logic       cs_lvl_d;

   spl_sync #(
      .WIDTH (2),
      .INIT  (1'h1)
   ) i_spl_sync (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .async_in ({wp_n, cs_n}),
      .level    (pins_lvl)
   );

   wire logic cs_lvl    = pins_lvl[0];
   wire logic wp_lvl_n  = pins_lvl[1];
   wire logic release_e = cs_lvl & ~cs_lvl_d;

   // Delayed chip select level for release detection.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cs_lvl_d <= 1'h1;
      end else begin
         cs_lvl_d <= cs_lvl;
      end
   end

   // ****************************************************************
   // Command evaluation at release.
   // ****************************************************************
   // Link registers are static after release, so they are read directly.
   wire logic [IDX_W-1:0] wr_idx  = addr_sh[SECTOR_SHIFT +: IDX_W];
   wire logic op_done  = started_cnt_ok(spl_pkg::BITS_OPCODE);
   wire logic addr_ok  = started_cnt_ok(spl_pkg::BITS_ADDR);
   wire logic data_ok  = started_cnt_ok(spl_pkg::BITS_DATA);
   wire logic hw_lock  = ~wp_lvl_n & protect_regs_lock_bit;
   wire logic prot_op  = op_done && spl_pkg::is_prot_write(opcode);
   wire logic stat_op  = op_done && (opcode == spl_pkg::OP_WR_STAT);
   wire logic sect_ok  = prot_op && addr_ok && write_enable_latch &&
                         !protect_regs_lock_bit;
   wire logic lock_ok  = stat_op && data_ok && write_enable_latch &&
                         !hw_lock && !(~wp_lvl_n && !data_msb);
   wire logic sect_val = (opcode == spl_pkg::OP_PROTECT);

   // Count test on the frame just finished.
   function automatic logic started_cnt_ok(input logic [5:0] need);
      started_cnt_ok = (bit_cnt >= need);
   endfunction

   logic next_latch;
   logic next_lock;

   // Latch: set and clear commands, cleared by any protection write.
   always_comb begin
      next_latch = write_enable_latch;
      if (release_e && op_done) begin
         if (opcode == spl_pkg::OP_WR_EN) begin
            next_latch = 1'h1;
         end else if (opcode == spl_pkg::OP_WR_DIS) begin
            next_latch = 1'h0;
         end else if (prot_op || stat_op) begin
            next_latch = 1'h0;
         end
      end
   end

   // Lock bit: frozen by hardware lock, 1 to 0 only with the pin high.
   always_comb begin
      next_lock = protect_regs_lock_bit;
      if (release_e && lock_ok) begin
         next_lock = data_msb;
      end
   end

   // Latch and lock bit registers.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         write_enable_latch    <= spl_pkg::LATCH_RESET;
         protect_regs_lock_bit <= spl_pkg::LOCK_RESET;
      end else begin
         write_enable_latch    <= next_latch;
         protect_regs_lock_bit <= next_lock;
      end
   end

   // One flag per sector; only the addressed one may change.
   genvar s;
   generate
      for (s = 0; s < SECTORS; s++) begin : g_sect
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               sector_protect_bit[s] <= spl_pkg::PROT_RESET;
            end else if (release_e && sect_ok && wr_idx == s) begin
               sector_protect_bit[s] <= sect_val;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Status outputs.
   // ****************************************************************
   // Summary of all flags; the pin plays no part in protection.
   wire logic all_set  = &sector_protect_bit;
   wire logic none_set = ~|sector_protect_bit;

   assign protect_summary_field = all_set  ? spl_pkg::SUM_ALL  :
                                  none_set ? spl_pkg::SUM_NONE :
                                             spl_pkg::SUM_SOME;
   assign wp_pin_status = wp_lvl_n;

endmodule

// ---- tb/spl_sector_lock_sva.sv ----
`timescale 1ns/1ps
// Watches the protection state and the read path of the lock block.
module spl_sector_lock_sva #(
   parameter int SECTORS = 16
) (
   input wire logic               sys_clk,
   input wire logic               rst,
   input wire logic               spi_clk,
   input wire logic               cs_n,
   input wire logic               si,
   input wire logic               so,
   input wire logic               so_oe_n,
   input wire logic               wp_n,
   input wire logic               write_enable_latch,
   input wire logic               protect_regs_lock_bit,
   input wire logic [1:0]         protect_summary_field,
   input wire logic               wp_pin_status,
   input wire logic [SECTORS-1:0] sector_protect_bit
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   reset_state_a: assert property (disable iff (1'b0) rst |=>
      &sector_protect_bit && !protect_regs_lock_bit && !write_enable_latch)
      else $error("state after reset is wrong");
   summary_code_a: assert property (protect_summary_field ==
      (&sector_protect_bit ? 2'h3 : (|sector_protect_bit ? 2'h1 : 2'h0)))
      else $error("summary field disagrees with sector bits");
   idle_float_a: assert property (cs_n |-> so_oe_n)
      else $error("output driven while deselected");
   read_value_a: assert property (!so_oe_n &&
      (&sector_protect_bit || ~|sector_protect_bit) |->
      so == sector_protect_bit[0]) else $error("read data wrong");
   lock_freeze_a: assert property (protect_regs_lock_bit |=>
      $stable(sector_protect_bit)) else $error("locked bits changed");
   hw_lock_a: assert property (!wp_pin_status &&
      protect_regs_lock_bit |=> protect_regs_lock_bit)
      else $error("hardware lock left without reset");
   latch_gate_a: assert property ($changed(sector_protect_bit) |->
      $past(write_enable_latch) && !write_enable_latch)
      else $error("sector bit changed without latch");
   one_sector_a: assert property ($changed(sector_protect_bit) |->
      $onehot(sector_protect_bit ^ $past(sector_protect_bit)))
      else $error("more than one sector bit changed");
   lock_set_a: assert property ($rose(protect_regs_lock_bit) |->
      $past(write_enable_latch)) else $error("lock set without latch");
endmodule

bind spl_sector_lock spl_sector_lock_sva #(.SECTORS(SECTORS))
   i_spl_sector_lock_sva (.sys_clk(sys_clk), .rst(rst),
   .spi_clk(spi_clk), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n),
   .wp_n(wp_n), .write_enable_latch(write_enable_latch),
   .protect_regs_lock_bit(protect_regs_lock_bit),
   .protect_summary_field(protect_summary_field),
   .wp_pin_status(wp_pin_status), .sector_protect_bit(sector_protect_bit));

// ---- tb/spl_host.sv ----
`timescale 1ns/1ps
// Host serial controller in mode 0; the clock stands low between frames.
module spl_host (
   // Link toward the device.
   output logic      spi_clk,
   output logic      cs_n,
   output logic      si,
   // Read path from the device.
   input  wire logic so,
   input  wire logic so_oe_n
);
   // Idle levels before the first frame.
   // A definite rising chip select clears the link logic at start-up,
   // since a change out of the unknown level at time zero may be missed.
   initial begin
      spi_clk = 1'b0;
      cs_n    = 1'b0;
      si      = 1'b0;
      #1 cs_n = 1'b1;
   end

   // Sends n bits MSB first, then clocks in nrd bits of read data.
   task automatic xfer(input logic [39:0] tx, input int n, input int nrd,
                       output logic [15:0] rd);
      rd = 16'h0000;
      #3 cs_n = 1'b0;
      for (int i = 0; i < n + nrd; i++) begin
         si = (i < n) ? tx[39-i] : ~si; // Toggles on every bit past the frame.
         #62.5 spi_clk = 1'b1;
         if (i >= n) begin
            // Data counts only while the device drives the line.
            rd = {rd[14:0], (so_oe_n === 1'b0) ? so : 1'bx};
         end
         #62.5 spi_clk = 1'b0;
      end
      cs_n = 1'b1;
      si = ~si;
      #1000; // Gap lets the command land before the next frame.
   endtask
endmodule

// ---- tb/spl_sector_lock_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the sector protection and lock block.
module spl_sector_lock_tb;
   logic        sys_clk   = 1'b0;
   logic        rst       = 1'b1;
   logic        wp_n      = 1'b1;
   wire         spi_clk, cs_n, si, so, so_oe_n;
   wire         latch, lock, wp_st;
   wire  [1:0]  summ;
   wire  [15:0] spb;
   logic [15:0] rd;
   int          err_total = 0;
   int          tests_run = 0;

   // The system clock toggles every half period.
   always #20 sys_clk = ~sys_clk;

   spl_sector_lock i_spl_sector_lock (.sys_clk(sys_clk), .rst(rst),
      .spi_clk(spi_clk), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n),
      .wp_n(wp_n), .write_enable_latch(latch), .protect_regs_lock_bit(lock),
      .protect_summary_field(summ), .wp_pin_status(wp_st),
      .sector_protect_bit(spb));
   spl_host i_spl_host (.spi_clk(spi_clk), .cs_n(cs_n), .si(si),
      .so(so), .so_oe_n(so_oe_n));

   // ****************************************************************
   // Shared helpers.
   // ****************************************************************
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [39:0] tx, input int n);
      i_spl_host.xfer(tx, n, 0, rd);
   endtask
   task automatic wren();
      cmd({spl_pkg::OP_WR_EN, 32'h0}, 8);
   endtask
   task automatic set_wp(input logic lvl);
      @(negedge sys_clk) wp_n = lvl;
      repeat (6) @(negedge sys_clk);
   endtask

   // Scenarios.
   task automatic t_reset();
      chk({2'h0, lock, latch, spb}, 20'h0FFFF);
      chk({18'h0, summ}, 20'h3);
      chk({19'h0, wp_st}, 20'h1);
      i_spl_host.xfer({spl_pkg::OP_READ, 24'h000000, 8'h0}, 32, 12, rd);
      chk({4'h0, rd}, 20'h00FFF);
      $display("t_reset done");
   endtask
   task automatic t_clear();
      cmd({spl_pkg::OP_CLEAR, 24'h0BFFFF, 8'h00}, 32);
      chk({2'h0, lock, latch, spb}, 20'h0FFFF);
      wren();
      cmd({spl_pkg::OP_CLEAR, 24'h0BFFFF, 8'hA5}, 40);
      chk({2'h0, lock, latch, spb}, 20'h0FFDF);
      chk({18'h0, summ}, 20'h1);
      $display("t_clear done");
   endtask
   task automatic t_abort();
      wren();
      cmd({spl_pkg::OP_CLEAR, 24'h0C0000, 8'h00}, 20);
      chk({2'h0, lock, latch, spb}, 20'h0FFDF);
      wren();
      cmd({spl_pkg::OP_CLEAR, 32'h0}, 4);
      chk({2'h0, lock, latch, spb}, 20'h1FFDF);
      cmd({spl_pkg::OP_WR_DIS, 32'h0}, 8);
      $display("t_abort done");
   endtask
   task automatic t_read();
      set_wp(1'b0);
      chk({19'h0, wp_st}, 20'h0);
      i_spl_host.xfer({spl_pkg::OP_READ, 24'h0A0000, 8'h0}, 32, 12, rd);
      chk({4'h0, rd}, 20'h00000);
      i_spl_host.xfer({spl_pkg::OP_READ, 24'h0C0000, 8'h0}, 32, 12, rd);
      chk({4'h0, rd}, 20'h00FFF);
      chk({19'h0, so_oe_n}, 20'h1);
      set_wp(1'b1);
      $display("t_read done");
   endtask
   task automatic t_lock();
      wren();
      cmd({spl_pkg::OP_WR_STAT, 8'h80, 24'h0}, 16);
      chk({2'h0, lock, latch, spb}, 20'h2FFDF);
      wren();
      cmd({spl_pkg::OP_CLEAR, 24'h0C0000, 8'h00}, 32);
      chk({2'h0, lock, latch, spb}, 20'h2FFDF);
      set_wp(1'b0);
      wren();
      cmd({spl_pkg::OP_WR_STAT, 8'h00, 24'h0}, 16);
      chk({2'h0, lock, latch, spb}, 20'h2FFDF);
      set_wp(1'b1);
      wren();
      cmd({spl_pkg::OP_WR_STAT, 8'h00, 24'h0}, 16);
      chk({2'h0, lock, latch, spb}, 20'h0FFDF);
      $display("t_lock done");
   endtask
   // Lock set with the pin low, then a device reset in mid-run frees it.
   task automatic t_hw_reset();
      set_wp(1'b0);
      wren();
      cmd({spl_pkg::OP_WR_STAT, 8'h80, 24'h0}, 16);
      chk({2'h0, lock, latch, spb}, 20'h2FFDF);
      @(negedge sys_clk) rst = 1'b1;
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk({2'h0, lock, latch, spb}, 20'h0FFFF);
      set_wp(1'b1);
      $display("t_hw_reset done");
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("tests_run=%0d err_total=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Main sequence after reset.
   initial begin
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      repeat (2) @(negedge sys_clk);
      t_reset();
      t_clear();
      t_abort();
      t_read();
      t_lock();
      t_hw_reset();
      complete_run();
   end

   // Cuts a hang short well past the expected run time.
   initial begin
      #500000;
      err_total++;
      complete_run();
   end
endmodule
